// [rtl/host_link_pkg.sv]
/*
  Shared constants, packet carriers and the check-value step for the host packet link.
  Assumes a single 250 MHz clock and a user side that speaks in whole packets.
*/
package host_link_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int BAUD_DEFAULT = 19200;
  localparam int BAUD_FAST = 115200;
  localparam int DIV_W = 14;
  localparam logic [DIV_W-1:0] DIV_SLOW = DIV_W'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
  localparam logic [DIV_W-1:0] DIV_FAST = DIV_W'((CLK_HZ + BAUD_FAST / 2) / BAUD_FAST);

  localparam int MAX_PAYLOAD = 18;
  localparam logic [7:0] MAX_LEN = 8'h12;
  localparam logic [7:0] TYPE_KEY = 8'h80;
  localparam logic [7:0] TYPE_FAN = 8'h81;
  localparam logic [7:0] TYPE_TEMP = 8'h82;
  localparam logic [7:0] RSP_FLAG = 8'h40;
  localparam logic [7:0] ERR_FLAGS = 8'hC0;
  localparam logic [7:0] REPORT_LEN_KEY = 8'h01;
  localparam logic [7:0] REPORT_LEN_SENSOR = 8'h04;
  localparam logic [3:0] KEY_CODE_MIN = 4'h1;
  localparam logic [3:0] KEY_CODE_MAX = 4'hC;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'h8408;

  localparam int FAN_PERIOD_MS = 500;
  localparam int TEMP_PERIOD_MS = 1000;
  localparam int ACK_LIMIT_MS = 250;
  localparam int ACK_GUARD_MS = 200;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int FAN_PERIOD_CYC = FAN_PERIOD_MS * CYC_PER_MS;
  localparam int ACK_GUARD_CYC = ACK_GUARD_MS * CYC_PER_MS;

  localparam int FIFO_DEPTH = 8;
  localparam int RX_BUF_DEPTH = 32;
  localparam int NUM_FANS = 4;
  localparam int NUM_TEMPS = 32;
  localparam int NUM_KEYS = 12;

  typedef struct packed {
    logic [7:0] kind;
    logic [7:0] len;
    logic [MAX_PAYLOAD-1:0][7:0] data;
  } packet_t;

  typedef struct packed {
    logic [7:0] tach;
    logic [15:0] ticks;
  } fan_sample_t;

  typedef struct packed {
    logic [4:0] index;
    logic [15:0] temp;
    logic crcOk;
  } temp_sample_t;

  function automatic logic [15:0] crcStep(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
    end
    return c;
  endfunction
endpackage

// [rtl/byte_fifo.sv]
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; reader and writer may act in the same cycle.
*/
`timescale 1ns/1ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic doWrite;
  logic doRead;

  assign inReady = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData = mem[rdPtr_ff];
  assign doWrite = inValid && inReady;
  assign doRead = outValid && outReady;

  always_ff @(posedge clock)
  begin
    if (doWrite)
    begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (doRead)
      begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      end
      count_ff <= count_ff + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule // byte_fifo

// [rtl/uart_core.sv]
/*
  8N1 asynchronous serial receiver and transmitter with selectable bit rate.
  Assumes rxPin is asynchronous; txData comes from logic on the same clock.
*/
`timescale 1ns/1ps
module uart_core #(
  parameter logic [host_link_pkg::DIV_W-1:0] DIV_FAST = host_link_pkg::DIV_FAST
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic baudFast,
  input wire logic rxPin,
  output logic [7:0] rxData,
  output logic rxStrobe,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic txPin
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;

  logic [host_link_pkg::DIV_W-1:0] divisor;
  logic rxMeta_ff;
  logic rxSync_ff;
  rx_state_t rxState_ff;
  logic [host_link_pkg::DIV_W-1:0] rxCnt_ff;
  logic [2:0] rxBit_ff;
  logic [7:0] rxShift_ff;
  logic rxStrobe_ff;
  tx_state_t txState_ff;
  logic [host_link_pkg::DIV_W-1:0] txCnt_ff;
  logic [3:0] txBit_ff;
  logic [9:0] txShift_ff;
  logic txLine_ff;

  assign divisor = baudFast ? DIV_FAST : host_link_pkg::DIV_SLOW;
  assign rxData = rxShift_ff;
  assign rxStrobe = rxStrobe_ff;
  assign txReady = (txState_ff == TX_IDLE);
  assign txPin = txLine_ff;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rxMeta_ff <= 1'b1;
      rxSync_ff <= 1'b1;
    end
    else
    begin
      rxMeta_ff <= rxPin;
      rxSync_ff <= rxMeta_ff;
    end
  end

  // sample mid-bit; a bad stop bit drops the byte, the packet check then resyncs
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rxState_ff <= RX_IDLE;
      rxCnt_ff <= '0;
      rxBit_ff <= '0;
      rxShift_ff <= '0;
      rxStrobe_ff <= 1'b0;
    end
    else
    begin
      rxStrobe_ff <= 1'b0;
      if (rxState_ff != RX_IDLE && rxCnt_ff != '0)
      begin
        rxCnt_ff <= rxCnt_ff - 1'b1;
      end
      else
      begin
        case (rxState_ff)
          RX_IDLE:
          begin
            if (!rxSync_ff)
            begin
              rxCnt_ff <= divisor >> 1;
              rxState_ff <= RX_START;
            end
          end
          RX_START:
          begin
            rxCnt_ff <= divisor - 1'b1;
            rxBit_ff <= '0;
            rxState_ff <= rxSync_ff ? RX_IDLE : RX_DATA;
          end
          RX_DATA:
          begin
            rxShift_ff <= {rxSync_ff, rxShift_ff[7:1]};
            rxCnt_ff <= divisor - 1'b1;
            rxBit_ff <= rxBit_ff + 1'b1;
            if (rxBit_ff == 3'h7)
            begin
              rxState_ff <= RX_STOP;
            end
          end
          RX_STOP:
          begin
            rxStrobe_ff <= rxSync_ff;
            rxState_ff <= RX_IDLE;
          end
          default: rxState_ff <= RX_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      txState_ff <= TX_IDLE;
      txCnt_ff <= '0;
      txBit_ff <= '0;
      txShift_ff <= '1;
      txLine_ff <= 1'b1;
    end
    else
    begin
      case (txState_ff)
        TX_IDLE:
        begin
          if (txValid)
          begin
            txShift_ff <= {1'b1, txData, 1'b0};
            txLine_ff <= 1'b0;
            txCnt_ff <= divisor - 1'b1;
            txBit_ff <= '0;
            txState_ff <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (txCnt_ff != '0)
          begin
            txCnt_ff <= txCnt_ff - 1'b1;
          end
          else if (txBit_ff == 4'h9)
          begin
            txLine_ff <= 1'b1;
            txState_ff <= TX_IDLE;
          end
          else
          begin
            txShift_ff <= {1'b1, txShift_ff[9:1]};
            txLine_ff <= txShift_ff[1];
            txBit_ff <= txBit_ff + 1'b1;
            txCnt_ff <= divisor - 1'b1;
          end
        end
        default: txState_ff <= TX_IDLE;
      endcase
    end
  end
endmodule // uart_core

// [rtl/host_packet_link.sv]
/*
  Serial packet link toward the host: framing, check values, resync, acknowledges
  and unsolicited key, fan and temperature reports.
  Assumes the user side presents sensor samples and command answers on this clock.
*/
`timescale 1ns/1ps

module host_packet_link #(
  parameter int HALF_SEC_CYCLES = host_link_pkg::FAN_PERIOD_CYC,
  parameter int ACK_GUARD_CYCLES = host_link_pkg::ACK_GUARD_CYC,
  parameter logic [host_link_pkg::DIV_W-1:0] DIV_FAST = host_link_pkg::DIV_FAST
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic rxPin,
  output logic txPin,
  input wire logic baudFast,
  input wire logic keyEvent,
  input wire logic [3:0] keyCode,
  input wire logic [host_link_pkg::NUM_KEYS-1:0] keyMask,
  input wire logic fanSampleValid,
  input wire logic [1:0] fanIndex,
  input wire host_link_pkg::fan_sample_t fanSample,
  input wire logic [host_link_pkg::NUM_FANS-1:0] fanMask,
  input wire logic tempSampleValid,
  input wire host_link_pkg::temp_sample_t tempSample,
  input wire logic [host_link_pkg::NUM_TEMPS-1:0] tempMask,
  output logic cmdValid,
  output host_link_pkg::packet_t cmdPacket,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic rspError,
  input wire logic [7:0] rspLen,
  input wire logic [host_link_pkg::MAX_PAYLOAD-1:0][7:0] rspData,
  output logic rspReady
);
  localparam int BW = $clog2(host_link_pkg::RX_BUF_DEPTH);
  typedef enum logic {FR_IDLE, FR_SEND} frame_state_t;

  logic [7:0] rxByte;
  logic rxStrobe;
  logic fifoInReady;
  logic [7:0] fifoOutData;
  logic fifoOutValid;
  logic uartTxReady;
  logic [7:0] rxBuf [host_link_pkg::RX_BUF_DEPTH];
  logic [BW-1:0] wrPtr_ff;
  logic [BW-1:0] startPtr_ff;
  logic [BW-1:0] scanPtr_ff;
  logic [4:0] scanIdx_ff;
  logic [4:0] scanLen_ff;
  logic [15:0] scanCrc_ff;
  logic [7:0] crcLo_ff;
  host_link_pkg::packet_t scanPkt_ff;
  logic [7:0] scanByte;
  logic bufFull;
  logic scanGo;
  logic cmdValid_ff;
  host_link_pkg::packet_t cmdPacket_ff;
  logic awaiting_ff;
  logic [31:0] ackCnt_ff;
  logic rspPend_ff;
  host_link_pkg::packet_t rspPkt_ff;
  logic keyPend_ff;
  logic [3:0] keyCode_ff;
  host_link_pkg::fan_sample_t fanStore [host_link_pkg::NUM_FANS];
  logic [15:0] tempStore [host_link_pkg::NUM_TEMPS];
  logic [host_link_pkg::NUM_TEMPS-1:0] tempOk_ff;
  logic [host_link_pkg::NUM_FANS-1:0] fanDue_ff;
  logic [host_link_pkg::NUM_TEMPS-1:0] tempDue_ff;
  logic [31:0] halfCnt_ff;
  logic secondPhase_ff;
  logic halfTick;
  frame_state_t frState_ff;
  host_link_pkg::packet_t txPkt_ff;
  logic [4:0] txIdx_ff;
  logic [15:0] txCrc_ff;
  logic [7:0] txByte;
  logic [1:0] fanSel;
  logic fanHit;
  logic [4:0] tempSel;
  logic tempHit;
  logic launchRsp;
  logic launchKey;
  logic launchFan;
  logic launchTemp;
  host_link_pkg::packet_t nxt_txPkt;

  uart_core #(.DIV_FAST(DIV_FAST)) uart (
    .clock(clock), .nrst(nrst), .baudFast(baudFast), .rxPin(rxPin),
    .rxData(rxByte), .rxStrobe(rxStrobe), .txData(fifoOutData),
    .txValid(fifoOutValid), .txReady(uartTxReady), .txPin(txPin)
  );

  byte_fifo #(.WIDTH(8), .DEPTH(host_link_pkg::FIFO_DEPTH)) txFifo (
    .clock(clock), .nrst(nrst), .inValid(frState_ff == FR_SEND),
    .inReady(fifoInReady), .inData(txByte), .outValid(fifoOutValid),
    .outReady(uartTxReady), .outData(fifoOutData)
  );

  assign cmdValid = cmdValid_ff;
  assign cmdPacket = cmdPacket_ff;
  assign rspReady = awaiting_ff;

  // receive ring: raw bytes kept so a failed candidate can be rescanned one byte later
  assign bufFull = (wrPtr_ff + 1'b1) == startPtr_ff;
  assign scanByte = rxBuf[scanPtr_ff];
  // a held command stalls parsing; the host is expected to wait for the answer
  assign scanGo = (scanPtr_ff != wrPtr_ff) && !cmdValid_ff && !awaiting_ff;

  always_ff @(posedge clock)
  begin
    if (rxStrobe && !bufFull)
    begin
      rxBuf[wrPtr_ff] <= rxByte;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      wrPtr_ff <= '0;
    end
    else if (rxStrobe && !bufFull)
    begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      startPtr_ff <= '0;
      scanPtr_ff <= '0;
      scanIdx_ff <= '0;
      scanLen_ff <= '0;
      scanCrc_ff <= host_link_pkg::CRC_INIT;
      crcLo_ff <= '0;
      scanPkt_ff <= '0;
      cmdValid_ff <= 1'b0;
      cmdPacket_ff <= '0;
    end
    else
    begin
      if (cmdValid_ff && cmdReady)
      begin
        cmdValid_ff <= 1'b0;
      end
      if (scanGo)
      begin
        scanPtr_ff <= scanPtr_ff + 1'b1;
        scanIdx_ff <= scanIdx_ff + 1'b1;
        if (scanIdx_ff == 5'd0)
        begin
          scanPkt_ff <= '0;
          scanPkt_ff.kind <= scanByte;
          scanCrc_ff <= host_link_pkg::crcStep(host_link_pkg::CRC_INIT, scanByte);
        end
        else if (scanIdx_ff == 5'd1 && scanByte > host_link_pkg::MAX_LEN)
        begin
          startPtr_ff <= startPtr_ff + 1'b1;
          scanPtr_ff <= startPtr_ff + 1'b1;
          scanIdx_ff <= '0;
        end
        else if (scanIdx_ff == 5'd1)
        begin
          scanPkt_ff.len <= scanByte;
          scanLen_ff <= scanByte[4:0];
          scanCrc_ff <= host_link_pkg::crcStep(scanCrc_ff, scanByte);
        end
        else if (scanIdx_ff < scanLen_ff + 5'd2)
        begin
          scanPkt_ff.data[scanIdx_ff - 5'd2] <= scanByte;
          scanCrc_ff <= host_link_pkg::crcStep(scanCrc_ff, scanByte);
        end
        else if (scanIdx_ff == scanLen_ff + 5'd2)
        begin
          crcLo_ff <= scanByte;
        end
        else if ({scanByte, crcLo_ff} == ~scanCrc_ff)
        begin
          startPtr_ff <= scanPtr_ff + 1'b1;
          scanIdx_ff <= '0;
          cmdValid_ff <= 1'b1;
          cmdPacket_ff <= scanPkt_ff;
        end
        else
        begin
          startPtr_ff <= startPtr_ff + 1'b1;
          scanPtr_ff <= startPtr_ff + 1'b1;
          scanIdx_ff <= '0;
        end
      end
    end
  end

  // guard below the limit leaves time for the answer to get out on the line
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      awaiting_ff <= 1'b0;
      ackCnt_ff <= '0;
      rspPend_ff <= 1'b0;
      rspPkt_ff <= '0;
    end
    else
    begin
      if (launchRsp)
      begin
        rspPend_ff <= 1'b0;
      end
      if (scanGo && !cmdValid_ff && scanIdx_ff > 5'd2 && scanIdx_ff == scanLen_ff + 5'd3
          && {scanByte, crcLo_ff} == ~scanCrc_ff)
      begin
        awaiting_ff <= 1'b1;
        ackCnt_ff <= '0;
      end
      else if (awaiting_ff && rspValid)
      begin
        awaiting_ff <= 1'b0;
        rspPend_ff <= 1'b1;
        rspPkt_ff.kind <= (rspError ? host_link_pkg::ERR_FLAGS : host_link_pkg::RSP_FLAG)
          | {2'b00, cmdPacket_ff.kind[5:0]};
        rspPkt_ff.len <= (rspLen > host_link_pkg::MAX_LEN) ? host_link_pkg::MAX_LEN : rspLen;
        rspPkt_ff.data <= rspData;
      end
      else if (awaiting_ff && ackCnt_ff == 32'(ACK_GUARD_CYCLES - 1))
      begin
        awaiting_ff <= 1'b0;
        rspPend_ff <= 1'b1;
        rspPkt_ff <= '0;
        rspPkt_ff.kind <= host_link_pkg::ERR_FLAGS | {2'b00, cmdPacket_ff.kind[5:0]};
      end
      else if (awaiting_ff)
      begin
        ackCnt_ff <= ackCnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      keyPend_ff <= 1'b0;
      keyCode_ff <= '0;
    end
    else if (keyEvent && keyCode >= host_link_pkg::KEY_CODE_MIN
             && keyCode <= host_link_pkg::KEY_CODE_MAX && keyMask[keyCode - 4'h1])
    begin
      keyPend_ff <= 1'b1;
      keyCode_ff <= keyCode;
    end
    else if (launchKey)
    begin
      keyPend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (fanSampleValid)
    begin
      fanStore[fanIndex] <= fanSample;
    end
    if (tempSampleValid)
    begin
      tempStore[tempSample.index] <= tempSample.temp;
    end
  end

  assign halfTick = (halfCnt_ff == 32'(HALF_SEC_CYCLES - 1));

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      halfCnt_ff <= '0;
      secondPhase_ff <= 1'b0;
      fanDue_ff <= '0;
      tempDue_ff <= '0;
      tempOk_ff <= '0;
    end
    else
    begin
      halfCnt_ff <= halfTick ? '0 : halfCnt_ff + 1'b1;
      if (halfTick)
      begin
        secondPhase_ff <= !secondPhase_ff;
      end
      if (tempSampleValid)
      begin
        tempOk_ff[tempSample.index] <= tempSample.crcOk;
      end
      // a new period's request wins over the clear of the one just sent
      fanDue_ff <= (fanDue_ff & ~(launchFan ? (4'h1 << fanSel) : 4'h0))
        | (halfTick ? fanMask : 4'h0);
      tempDue_ff <= (tempDue_ff & ~(launchTemp ? (32'h1 << tempSel) : 32'h0))
        | ((halfTick && secondPhase_ff) ? tempMask : 32'h0);
    end
  end

  always_comb
  begin
    fanSel = '0;
    fanHit = 1'b0;
    tempSel = '0;
    tempHit = 1'b0;
    for (int i = host_link_pkg::NUM_FANS - 1; i >= 0; i--)
    begin
      if (fanDue_ff[i])
      begin
        fanHit = 1'b1;
        fanSel = 2'(i);
      end
    end
    for (int i = host_link_pkg::NUM_TEMPS - 1; i >= 0; i--)
    begin
      if (tempDue_ff[i])
      begin
        tempHit = 1'b1;
        tempSel = 5'(i);
      end
    end
  end

  // answers first; reports slot in between whenever the framer is free
  assign launchRsp = (frState_ff == FR_IDLE) && rspPend_ff;
  assign launchKey = (frState_ff == FR_IDLE) && !rspPend_ff && keyPend_ff;
  assign launchFan = (frState_ff == FR_IDLE) && !rspPend_ff && !keyPend_ff && fanHit;
  assign launchTemp = (frState_ff == FR_IDLE) && !rspPend_ff && !keyPend_ff && !fanHit
    && tempHit;

  always_comb
  begin
    nxt_txPkt = rspPkt_ff;
    if (launchKey)
    begin
      nxt_txPkt = '0;
      nxt_txPkt.kind = host_link_pkg::TYPE_KEY;
      nxt_txPkt.len = host_link_pkg::REPORT_LEN_KEY;
      nxt_txPkt.data[0] = {4'h0, keyCode_ff};
    end
    else if (launchFan)
    begin
      nxt_txPkt = '0;
      nxt_txPkt.kind = host_link_pkg::TYPE_FAN;
      nxt_txPkt.len = host_link_pkg::REPORT_LEN_SENSOR;
      nxt_txPkt.data[0] = {6'h00, fanSel};
      nxt_txPkt.data[1] = fanStore[fanSel].tach;
      nxt_txPkt.data[2] = fanStore[fanSel].ticks[15:8];
      nxt_txPkt.data[3] = fanStore[fanSel].ticks[7:0];
    end
    else if (launchTemp)
    begin
      nxt_txPkt = '0;
      nxt_txPkt.kind = host_link_pkg::TYPE_TEMP;
      nxt_txPkt.len = host_link_pkg::REPORT_LEN_SENSOR;
      nxt_txPkt.data[0] = {3'h0, tempSel};
      nxt_txPkt.data[1] = tempStore[tempSel][7:0];
      nxt_txPkt.data[2] = tempStore[tempSel][15:8];
      nxt_txPkt.data[3] = {7'h00, tempOk_ff[tempSel]};
    end
  end

  always_comb
  begin
    if (txIdx_ff == 5'd0)
      txByte = txPkt_ff.kind;
    else if (txIdx_ff == 5'd1)
      txByte = txPkt_ff.len;
    else if (txIdx_ff < txPkt_ff.len[4:0] + 5'd2)
      txByte = txPkt_ff.data[txIdx_ff - 5'd2];
    else if (txIdx_ff == txPkt_ff.len[4:0] + 5'd2)
      txByte = ~txCrc_ff[7:0];
    else
      txByte = ~txCrc_ff[15:8];
  end

  // pacing comes only from the FIFO stalling the framer, nothing on the line
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      frState_ff <= FR_IDLE;
      txPkt_ff <= '0;
      txIdx_ff <= '0;
      txCrc_ff <= host_link_pkg::CRC_INIT;
    end
    else
    begin
      case (frState_ff)
        FR_IDLE:
        begin
          if (launchRsp || launchKey || launchFan || launchTemp)
          begin
            txPkt_ff <= nxt_txPkt;
            txIdx_ff <= '0;
            txCrc_ff <= host_link_pkg::CRC_INIT;
            frState_ff <= FR_SEND;
          end
        end
        FR_SEND:
        begin
          if (fifoInReady)
          begin
            txIdx_ff <= txIdx_ff + 1'b1;
            if (txIdx_ff < txPkt_ff.len[4:0] + 5'd2)
            begin
              txCrc_ff <= host_link_pkg::crcStep(txCrc_ff, txByte);
            end
            if (txIdx_ff == txPkt_ff.len[4:0] + 5'd3)
            begin
              frState_ff <= FR_IDLE;
            end
          end
        end
        default: frState_ff <= FR_IDLE;
      endcase
    end
  end
endmodule // host_packet_link

// [testbench/host_packet_link_monitor.sv]
/*
  Port checker for the host packet link: command hold, answer handshake, idle after reset.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module host_packet_link_monitor #(
  parameter int ACK_GUARD_CYCLES = 500
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic txPin,
  input wire logic cmdValid,
  input wire host_link_pkg::packet_t cmdPacket,
  input wire logic cmdReady,
  input wire logic rspValid,
  input wire logic rspReady
);
  int waitCnt_ff;
  always_ff @(posedge clock)
  begin
    if (!nrst || !rspReady)
      waitCnt_ff <= 0;
    else
      waitCnt_ff <= waitCnt_ff + 1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_rst_idle;
    $rose(nrst) |-> txPin && !cmdValid && !rspReady;
  endproperty
  property p_cmd_hold;
    cmdValid && !cmdReady |=> cmdValid && $stable(cmdPacket);
  endproperty
  property p_cmd_drop;
    cmdValid && cmdReady |=> !cmdValid;
  endproperty
  property p_len_ok;
    cmdValid |-> cmdPacket.len <= host_link_pkg::MAX_LEN;
  endproperty
  property p_rsp_take;
    rspValid && rspReady |=> !rspReady;
  endproperty
  property p_rsp_arm;
    $rose(cmdValid) |-> rspReady;
  endproperty
  property p_rsp_cause;
    $rose(rspReady) |-> $rose(cmdValid);
  endproperty
  property p_ack_bound;
    waitCnt_ff <= ACK_GUARD_CYCLES + 4;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("not idle after reset");
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed");
  a_cmd_drop: assert property (p_cmd_drop) else $error("command not dropped");
  a_len_ok: assert property (p_len_ok) else $error("length over limit");
  a_rsp_take: assert property (p_rsp_take) else $error("answer not taken");
  a_rsp_arm: assert property (p_rsp_arm) else $error("answer not armed");
  a_rsp_cause: assert property (p_rsp_cause) else $error("answer armed alone");
  a_ack_bound: assert property (p_ack_bound) else $error("answer wait too long");
  c_cmd: cover property (cmdValid && cmdReady);
  c_rsp: cover property (rspValid && rspReady);
  c_tx: cover property ($fell(txPin));
endmodule // host_packet_link_monitor

bind host_packet_link host_packet_link_monitor #(.ACK_GUARD_CYCLES(ACK_GUARD_CYCLES)) mon_u (
  .clock(clock), .nrst(nrst), .txPin(txPin), .cmdValid(cmdValid), .cmdPacket(cmdPacket),
  .cmdReady(cmdReady), .rspValid(rspValid), .rspReady(rspReady));

// [testbench/host_model.sv]
/*
  Host side of the serial link: 8N1 sender and packet collector at the fast rate.
  Assumes BIT equals the design's fast-rate bit divisor.
*/
`timescale 1ns/1ps
module host_model #(parameter int BIT = host_link_pkg::DIV_FAST) (
  input wire logic clock,
  input wire logic txPin,
  output logic rxPin
);
  initial rxPin = 1'b1;
  function automatic logic [15:0] crcAdd(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    return c;
  endfunction
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock);
      rxPin <= f[i];
      repeat (BIT - 1) @(posedge clock);
    end
  endtask
  // length-0 command; the check goes out inverted, low byte first
  task automatic sendCmd(input logic [7:0] t);
    logic [15:0] c;
    c = ~crcAdd(crcAdd(16'hFFFF, t), 8'h00);
    sendByte(t);
    sendByte(8'h00);
    sendByte(c[7:0]);
    sendByte(c[15:8]);
  endtask
  task automatic getByte(output logic [7:0] b);
    while (txPin !== 1'b0) @(posedge clock);
    repeat (BIT / 2) @(posedge clock);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT) @(posedge clock);
      b[i] = txPin;
    end
    repeat (BIT) @(posedge clock);
  endtask
  task automatic getPacket(output host_link_pkg::packet_t p, output logic ok);
    logic [7:0] b;
    logic [7:0] h;
    logic [15:0] c;
    p = '0;
    getByte(p.kind);
    getByte(p.len);
    c = crcAdd(crcAdd(16'hFFFF, p.kind), p.len);
    for (int i = 0; i < p.len && i < 18; i++)
    begin
      getByte(b);
      p.data[i] = b;
      c = crcAdd(c, b);
    end
    getByte(b);
    getByte(h);
    ok = ({h, b} === ~c);
  endtask
endmodule // host_model

// [testbench/host_packet_link_bench.sv]
/*
  Self-checking bench: resync after a junk byte, command answer, key and fan reports.
  Assumes the host model above and shortened bit, report and guard periods.
*/
`timescale 1ns/1ps
module host_packet_link_bench;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic keyEvent = 1'b0, fanSampleValid = 1'b0, cmdReady = 1'b0, rspValid = 1'b0;
  logic rspError = 1'b0, tempSampleValid = 1'b0;
  logic [31:0] tempMask = 32'h0;
  logic [3:0] keyCode = 4'h0;
  logic [11:0] keyMask = 12'h000;
  logic [1:0] fanIndex = 2'h0;
  logic [3:0] fanMask = 4'h0;
  logic [7:0] rspLen = 8'h00;
  logic [17:0][7:0] rspData = '0;
  host_link_pkg::fan_sample_t fanVal = '0;
  host_link_pkg::temp_sample_t tempVal = '0;
  host_link_pkg::packet_t pkt, cmdPacket;
  logic txPin, rxPin, cmdValid, rspReady, crcOk, gotKey = 1'b0, gotAns = 1'b0;
  logic [7:0] cmdType, junk, ansByte, code, off;
  int fail_count = 0, num_checks = 0, cyc = 0;
  always #2 clock = ~clock;
  host_packet_link #(.HALF_SEC_CYCLES(2000), .ACK_GUARD_CYCLES(500), .DIV_FAST(14'h40)) dut_u (
    .clock(clock), .nrst(nrst), .rxPin(rxPin), .txPin(txPin), .baudFast(1'b1),
    .keyEvent(keyEvent), .keyCode(keyCode), .keyMask(keyMask),
    .fanSampleValid(fanSampleValid), .fanIndex(fanIndex), .fanSample(fanVal),
    .fanMask(fanMask), .tempSampleValid(tempSampleValid), .tempSample(tempVal),
    .tempMask(tempMask),
    .cmdValid(cmdValid), .cmdPacket(cmdPacket), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspError(rspError), .rspLen(rspLen), .rspData(rspData), .rspReady(rspReady));
  host_model #(.BIT(32'h40)) host_u (.clock(clock), .txPin(txPin), .rxPin(rxPin));
  function automatic logic [7:0] expAns(input logic [7:0] t, input logic e);
    return (e ? 8'hC0 : 8'h40) | (t & 8'h3F);
  endfunction
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      fail_count++;
      stop_test();
    end
  end
  initial
  begin
    void'($urandom(29158));
    code = 8'($urandom_range(1, 12));
    off = (code % 8'h0C) + 8'h01;
    cmdType = 8'($urandom_range(8'h13, 8'h3F));
    junk = 8'($urandom);
    ansByte = 8'($urandom);
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    fanVal <= 24'($urandom);
    fanSampleValid <= 1'b1;
    fanMask <= 4'h1;
    keyMask <= (12'($urandom) | (12'h1 << (code - 1))) & ~(12'h1 << (off - 1));
    rspError <= 1'($urandom);
    @(posedge clock);
    fanSampleValid <= 1'b0;
    fork
      begin
        host_u.sendByte(junk);
        host_u.sendCmd(cmdType);
      end
      begin
        while (cmdValid !== 1'b1) @(posedge clock);
        check("cmd", {24'h0, cmdType, 8'h00}, {24'h0, cmdPacket.kind, cmdPacket.len});
        cmdReady <= 1'b1;
        rspValid <= 1'b1;
        rspLen <= 8'h01;
        rspData[0] <= ansByte;
        @(posedge clock);
        cmdReady <= 1'b0;
        rspValid <= 1'b0;
      end
      begin
        // events wait for the first report so that a stray overwrite would show
        while (txPin !== 1'b0) @(posedge clock);
        keyCode <= code[3:0];
        keyEvent <= 1'b1;
        @(posedge clock);
        keyCode <= off[3:0];
        @(posedge clock);
        keyEvent <= 1'b0;
      end
      for (int n = 0; n < 6 && !(gotKey && gotAns); n++)
      begin
        host_u.getPacket(pkt, crcOk);
        check("crc", 40'h1, {39'h0, crcOk});
        if (pkt.kind === host_link_pkg::TYPE_FAN)
          check("fan", {16'h0400, fanVal},
                {pkt.len, pkt.data[0], pkt.data[1], pkt.data[2], pkt.data[3]});
        else if (pkt.kind === host_link_pkg::TYPE_KEY)
        begin
          gotKey = 1'b1;
          check("key", {24'h0, 8'h01, code}, {24'h0, pkt.len, pkt.data[0]});
        end
        else
        begin
          gotAns = 1'b1;
          check("ans", {16'h0, expAns(cmdType, rspError), 8'h01, ansByte},
                {16'h0, pkt.kind, pkt.len, pkt.data[0]});
        end
      end
    join
    check("seen", 40'h3, {38'h0, gotKey, gotAns});
    stop_test();
  end
endmodule // host_packet_link_bench
